// ### hdl/mpp_top.sv
// Purpose: post-processing of converter results into trimmed registers
// Assumes: converter answers each start with one convDone pulse
// Notes:   classic wishbone slave, one wait state on every access
//          trims are frozen at each start, so a write never tears a result
//          results saturate; no sticky overflow flag is kept
`timescale 1ns/1ps
`include "mpp_consts.svh"

module mpp_top
	import mpp_pkg::*;
(
	// clock and reset
	input  wire logic        clock,
	input  wire logic        rstn,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [9:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// converter side
	output logic             convStart,
	output logic      [2:0]  convSel,
	output logic             tempExtSel,
	input  wire logic        convDone,
	input  wire logic [15:0] convData
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	mpp_state_t state_ff;  // every register of the block
	mpp_state_t nxt_state; // next value

	// clamp to signed 16 bits, never wrap
	// a wrapped charge current would read as a large discharge
	function automatic logic [15:0] sat16(input longint v);
		if (v > 64'sd32767) begin
			return 16'h7fff;
		end else if (v < -64'sd32768) begin
			return 16'h8000;
		end
		return v[15:0];
	endfunction

	// clamp to unsigned 16 bits
	function automatic logic [15:0] satu16(input longint v);
		if (v > 64'sd65535) begin
			return 16'hffff;
		end else if (v < 64'sd0) begin
			return 16'h0000;
		end
		return v[15:0];
	endfunction

	// byte-lane merge for 16-bit registers
	function automatic logic [15:0] lanes(input logic [15:0] old);
		logic [15:0] r;
		r = old;
		if (wb_sel_i[0]) begin
			r[7:0] = wb_dat_i[7:0];
		end
		if (wb_sel_i[1]) begin
			r[15:8] = wb_dat_i[15:8];
		end
		return r;
	endfunction

	// ----------------------------------------
	// next-state logic
	// ----------------------------------------
	// the ack flop blocks a second take of a request still held
	logic [7:0] idx; // word index from byte address
	logic       req; // new bus request this cycle
	assign idx = wb_adr_i[9:2];
	assign req = wb_cyc_i && wb_stb_i && !state_ff.ack;

	always_comb begin
		// wide scratch values: no product overflows before the clamp
		longint g, gs, c, m, t, raw, tc, dT;
		g   = 0;
		gs  = 0;
		c   = 0;
		m   = 0;
		t   = 0;
		raw = 0;
		tc  = 0;
		dT  = 0;
		// pulses default low, every other field holds
		nxt_state       = state_ff;
		nxt_state.start = 1'b0;
		nxt_state.ack   = 1'b0;

		// bus: writes land on the acknowledging edge
		if (req) begin
			nxt_state.ack = 1'b1;
			nxt_state.dat = 32'h0000_0000; // unmapped reads as zero
			if (idx == `MPP_IDX_RATIO) begin
				// read-only, writes dropped but still acked
				nxt_state.dat[15:0] = state_ff.ratioRes;
			end else if (idx == `MPP_IDX_THERMISTOR_GAIN_TRIM) begin
				nxt_state.dat[15:0] = state_ff.thermistor_gain_trim;
				if (wb_we_i) nxt_state.thermistor_gain_trim = lanes(state_ff.thermistor_gain_trim);
			end else if (idx == `MPP_IDX_THERMISTOR_OFFSET_TRIM) begin
				nxt_state.dat[15:0] = state_ff.thermistor_offset_trim;
				if (wb_we_i) nxt_state.thermistor_offset_trim = lanes(state_ff.thermistor_offset_trim);
			end else if (idx == `MPP_IDX_CURRENT_GAIN_TRIM) begin
				nxt_state.dat[15:0] = state_ff.current_gain_trim;
				if (wb_we_i) nxt_state.current_gain_trim = lanes(state_ff.current_gain_trim);
			end else if (idx == `MPP_IDX_CURRENT_OFFSET_TRIM) begin
				nxt_state.dat[15:0] = state_ff.current_offset_trim;
				if (wb_we_i) nxt_state.current_offset_trim = lanes(state_ff.current_offset_trim);
			end else if (idx == `MPP_IDX_CTRL) begin
				// bit0 picks the thermistor path for the next start
				nxt_state.dat[`MPP_CTRL_EXT_BIT] = state_ff.ctrlExt;
				if (wb_we_i && wb_sel_i[0]) begin
					nxt_state.ctrlExt = wb_dat_i[`MPP_CTRL_EXT_BIT];
				end
			end else if (idx == `MPP_IDX_CURRENT) begin
				// results are read-only
				nxt_state.dat[15:0] = state_ff.curRes;
			end else if (idx == `MPP_IDX_TEMP) begin
				nxt_state.dat[15:0] = state_ff.tempRes;
			end else if (idx == `MPP_IDX_VOLT) begin
				nxt_state.dat[15:0] = state_ff.voltRes;
			end else if (idx == `MPP_IDX_PCT) begin
				nxt_state.dat[15:0] = state_ff.pctRes;
			end else if (idx == `MPP_IDX_TEMPCO) begin
				// zero turns die compensation off
				nxt_state.dat[15:0] = state_ff.tco;
				if (wb_we_i) nxt_state.tco = lanes(state_ff.tco);
			end else if (idx == `MPP_IDX_CURVE) begin
				nxt_state.dat[15:0] = state_ff.curve;
				if (wb_we_i) nxt_state.curve = lanes(state_ff.curve);
			end
		end

		// sequencer: start, freeze trims, wait for result
		if (!state_ff.busy) begin
			nxt_state.busy   = 1'b1;
			nxt_state.start  = 1'b1;
			nxt_state.ext    = state_ff.ctrlExt;
			nxt_state.sCgain = state_ff.current_gain_trim;
			nxt_state.sCoff  = state_ff.current_offset_trim;
			nxt_state.sTco   = state_ff.tco;
			nxt_state.sCurve = state_ff.curve;
			nxt_state.sTgain = state_ff.thermistor_gain_trim;
			nxt_state.sToff  = state_ff.thermistor_offset_trim;
		end else if (convDone) begin
			// a done pulse while idle never reaches this branch
			nxt_state.busy = 1'b0;
			raw = longint'($signed(convData));
			case (state_ff.seq)
				S_VOLT: begin
					// voltage reported as read
					nxt_state.voltRes = convData;
					nxt_state.seq     = S_TEMP;
				end
				S_TEMP: begin
					nxt_state.seq = S_CURR;
					if (state_ff.ext) begin
						// ratio kept as read, then percent in upper byte
						nxt_state.ratioRes = convData;
						nxt_state.pctRes   = satu16((longint'(convData)
							* `MPP_PCT_MUL) >>> `MPP_PCT_SHIFT);
						// gain, offset, then thermistor square term
						t = ((longint'(convData)
							* longint'($signed(state_ff.sTgain)))
							>>> `MPP_THERMISTOR_GAIN_TRIM_SHIFT)
							+ longint'($signed(state_ff.sToff));
						t = t + ((((t * t) >>> 16)
							* longint'(state_ff.sCurve[7:0]))
							>>> `MPP_TC_SHIFT);
						nxt_state.tempRes = sat16(t);
					end else begin
						// internal path bypasses all thermistor trims
						nxt_state.tempRes = convData;
						// kept for the tempco term of later currents
						nxt_state.die     = convData;
					end
				end
				S_CURR: begin
					nxt_state.seq = S_VOLT;
					// trim first, clamp before corrections
					g = ((raw * longint'($signed(state_ff.sCgain)))
						>>> `MPP_CURRENT_GAIN_TRIM_SHIFT)
						+ longint'($signed(state_ff.sCoff));
					gs = longint'($signed(sat16(g)));
					// die temperature scaling, skipped when zero
					if (state_ff.sTco != 16'h0000) begin
						tc = longint'(state_ff.sTco);
						dT = longint'($signed(state_ff.die))
							- longint'(`MPP_REF_TEMP);
						c = ((((gs * tc) >>> 16) * dT)
							* `MPP_TCO_STEP) >>> `MPP_TCO_SHIFT;
					end
					// trace self-heating grows with current squared
					m = (gs * (gs < 0 ? -gs : gs)
						* longint'($signed(state_ff.sCurve[15:8])))
						>>> `MPP_MC_SHIFT;
					// signed result, span fixed by 16-bit word
					nxt_state.curRes = sat16(gs + c + m);
				end
				default: begin
					// illegal code: restart the round
					nxt_state.seq = S_VOLT;
				end
			endcase
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	// async reset loads the power-up trims; results clear
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			state_ff          <= '0;
			state_ff.seq      <= S_VOLT;
			state_ff.current_gain_trim    <= `MPP_RST_CURRENT_GAIN_TRIM;
			state_ff.current_offset_trim     <= `MPP_RST_CURRENT_OFFSET_TRIM;
			state_ff.thermistor_gain_trim    <= `MPP_RST_THERMISTOR_GAIN_TRIM;
			state_ff.thermistor_offset_trim     <= `MPP_RST_THERMISTOR_OFFSET_TRIM;
			state_ff.tco      <= `MPP_RST_TEMPCO;
			state_ff.curve    <= `MPP_RST_CURVE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// outputs straight from flops
	// convSel is the one-hot state itself, so it never glitches
	assign wb_dat_o   = state_ff.dat;
	assign wb_ack_o   = state_ff.ack;
	assign convStart  = state_ff.start;
	assign convSel    = state_ff.seq;
	assign tempExtSel = state_ff.ext;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);

	// one pulse per access, even with stb still high
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held two cycles");

	// a held request is answered on the next edge
	a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not answered");

	// registers are 16 bits wide, upper lanes read zero
	a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
		else $error("upper read lanes not zero");

	// the next measurement starts two edges after a result
	a_conv_restart: assert property (convDone && state_ff.busy |=> ##1 convStart)
		else $error("no new conversion after result");

	// start is a single-cycle pulse
	a_start_pulse: assert property (convStart |=> !convStart)
		else $error("start held two cycles");

	// every result moves the round on
	a_seq_advance: assert property (convDone && state_ff.busy
		|=> convSel != $past(convSel))
		else $error("round did not advance");

	// voltage result refreshed without a host request
	a_volt_store: assert property (convDone && state_ff.busy && convSel == S_VOLT
		|=> state_ff.voltRes == $past(convData))
		else $error("voltage not stored");

	// current result only moves on its own turn
	a_cur_hold: assert property (convDone && state_ff.busy && convSel != S_CURR
		|=> $stable(state_ff.curRes))
		else $error("current result changed off its turn");

	// power-up trims pass the raw reading through
	a_trim_default: assert property (convDone && state_ff.busy && convSel == S_CURR
		&& state_ff.sCgain == 16'h0400 && state_ff.sCoff == 16'h0000
		&& state_ff.sTco == 16'h0000 && state_ff.sCurve[15:8] == 8'h00
		|=> state_ff.curRes == $past(convData))
		else $error("default trims altered current");

	// one path for the whole conversion
	a_path_stable: assert property (state_ff.busy && $past(state_ff.busy)
		|-> $stable(tempExtSel))
		else $error("temperature path changed mid conversion");

	// path follows the select bit as it stood at the start
	a_ext_latch: assert property (convStart
		|-> tempExtSel == $past(state_ff.ctrlExt))
		else $error("path not taken from select bit");

	// die reading untouched while the thermistor path runs
	a_die_kept: assert property (convDone && state_ff.busy && convSel == S_TEMP
		&& tempExtSel |=> $stable(state_ff.die))
		else $error("die reading changed on external path");

	// internal reading bypasses every thermistor trim
	a_int_bypass: assert property (convDone && state_ff.busy && convSel == S_TEMP
		&& !tempExtSel |=> state_ff.tempRes == $past(convData))
		else $error("internal temperature altered");

	// internal path leaves the ratio result alone
	a_ratio_kept: assert property (convDone && state_ff.busy && convSel == S_TEMP
		&& !tempExtSel |=> $stable(state_ff.ratioRes))
		else $error("ratio changed on internal path");

	// ratio kept exactly as converted
	a_ratio_store: assert property (convDone && state_ff.busy && convSel == S_TEMP
		&& tempExtSel |=> state_ff.ratioRes == $past(convData))
		else $error("ratio not stored");

	// 2048 ratio counts read as 25 whole percent in the upper byte
	a_pct_scale: assert property (convDone && state_ff.busy && convSel == S_TEMP
		&& tempExtSel && convData == 16'h0800 |=> state_ff.pctRes == 16'h1900)
		else $error("percent result misscaled");

	// positive inputs with tempco off and a non-negative curve byte never turn negative
	a_no_wrap: assert property (convDone && state_ff.busy && convSel == S_CURR
		&& !convData[15] && !state_ff.sCgain[15] && !state_ff.sCoff[15]
		&& state_ff.sTco == 16'h0000 && !state_ff.sCurve[15]
		|=> !state_ff.curRes[15])
		else $error("current result wrapped");

	// snapshot holds while the conversion runs
	a_trim_frozen: assert property (state_ff.busy && $past(state_ff.busy)
		|-> $stable(state_ff.sCgain) && $stable(state_ff.sTgain))
		else $error("trim snapshot changed mid conversion");

endmodule // mpp_top

// ### hdl/mpp_consts.svh
// Purpose: register indices, reset values and scaling constants
// Assumes: byte address on the bus is four times the index
// Notes:   definitions only
`ifndef MPP_CONSTS_SVH
`define MPP_CONSTS_SVH

// ----------------------------------------
// register indices (byte address = 4 x index)
// ----------------------------------------
`define MPP_IDX_RATIO    8'h27
`define MPP_IDX_THERMISTOR_GAIN_TRIM    8'h2c
`define MPP_IDX_THERMISTOR_OFFSET_TRIM     8'h2d
`define MPP_IDX_CURRENT_GAIN_TRIM    8'h2e
`define MPP_IDX_CURRENT_OFFSET_TRIM     8'h2f
`define MPP_IDX_CTRL     8'h30
`define MPP_IDX_CURRENT  8'h31
`define MPP_IDX_TEMP     8'h32
`define MPP_IDX_VOLT     8'h33
`define MPP_IDX_PCT      8'h34
`define MPP_IDX_TEMPCO   8'hb8
`define MPP_IDX_CURVE    8'hb9

// ----------------------------------------
// reset values
// ----------------------------------------
`define MPP_RST_THERMISTOR_GAIN_TRIM    16'hee56
`define MPP_RST_THERMISTOR_OFFSET_TRIM     16'h1da4
`define MPP_RST_CURRENT_GAIN_TRIM    16'h0400
`define MPP_RST_CURRENT_OFFSET_TRIM     16'h0000
`define MPP_RST_TEMPCO   16'h0000
`define MPP_RST_CURVE    16'h0000

// ----------------------------------------
// field positions and scaling
// ----------------------------------------
`define MPP_CTRL_EXT_BIT 0
`define MPP_CURRENT_GAIN_TRIM_SHIFT  10
`define MPP_THERMISTOR_GAIN_TRIM_SHIFT  14
`define MPP_TCO_STEP     2046
`define MPP_TCO_SHIFT    24
`define MPP_REF_TEMP     16'h1900
`define MPP_MC_SHIFT     23
`define MPP_PCT_MUL      25
`define MPP_PCT_SHIFT    3
`define MPP_TC_SHIFT     8

`endif

// ### hdl/mpp_pkg.sv
// Purpose: types shared by the post-processing block
// Assumes: constants live in mpp_consts.svh
// Notes:   one-hot sequencer codes
package mpp_pkg;
	typedef enum logic [2:0] {
		S_VOLT = 3'b001,
		S_TEMP = 3'b010,
		S_CURR = 3'b100
	} mpp_seq_t;

	typedef struct packed {
		mpp_seq_t    seq;   // measurement in turn
		logic        busy;  // conversion running
		logic        start; // start pulse to converter
		logic        ext;   // path latched for this conversion
		logic [15:0] current_gain_trim, current_offset_trim, tco, curve, thermistor_gain_trim, thermistor_offset_trim;
		logic        ctrlExt;                   // software path select
		logic [15:0] sCgain, sCoff, sTco, sCurve; // trims frozen at start
		logic [15:0] sTgain, sToff;
		logic [15:0] die;                        // last die temperature
		logic [15:0] curRes, tempRes, voltRes, ratioRes, pctRes;
		logic        ack;
		logic [31:0] dat;
	} mpp_state_t;
endpackage

// ### dv/mpp_conv_model.sv
// Purpose: converter and thermistor divider stand-in
// Assumes: one conversion in flight at a time
// Notes:   latency alternates short and long
`timescale 1ns/1ps
module mpp_conv_model (
	// clock and reset
	input  wire logic        clock,
	input  wire logic        rstn,
	// converter link
	input  wire logic        convStart,
	input  wire logic [2:0]  convSel,
	input  wire logic        tempExtSel,
	output logic             convDone,
	output logic      [15:0] convData
);
	logic [3:0] cnt;  // cycles left to result
	logic       slow; // next answer is slow
	// ----------------------------------------
	// fixed readings per measurement
	// ----------------------------------------
	function automatic logic [15:0] pick(input logic [2:0] s, input logic e);
		case (s)
			3'b001:  return 16'h1234;
			3'b010:  return e ? 16'h0800 : 16'h3200; // ratio or a 50 degree die
			default: return 16'h2000;
		endcase
	endfunction
	// one answer per start; data is junk outside the done pulse
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			cnt <= 4'h0;
			slow <= 1'b0;
			convDone <= 1'b0;
			convData <= 16'h0000;
		end else begin
			convDone <= (cnt == 4'h1);
			convData <= (cnt == 4'h1) ? pick(convSel, tempExtSel) : ~convData;
			if (cnt != 4'h0) begin
				cnt <= cnt - 4'h1;
			end else if (convStart) begin
				cnt <= slow ? 4'h7 : 4'h2;
				slow <= ~slow;
			end
		end
	end
endmodule // mpp_conv_model

// ### dv/mpp_top_tb.sv
// Purpose: self-checking bench for the post-processing block
// Assumes: one wait state on the register bus
// Notes:   expected values worked out by hand from the trim math
`timescale 1ns/1ps
`include "mpp_consts.svh"
module mpp_top_tb;
	logic        clock, rstn, cyc, stb, we, ack;
	logic        extSeen = 1'b0; // path of the last temperature conversion
	logic [9:0]  adr;
	logic [3:0]  sel;
	logic [31:0] datI, datO;
	logic        convStart, tempExtSel, convDone;
	logic [2:0]  convSel;
	logic [15:0] convData;
	int          miscompares, checked;
	logic [15:0] g [4] = '{16'h0800, 16'h0800, 16'h7fff, 16'h8000};
	logic [15:0] o [4] = '{16'h0000, 16'h0010, 16'h0010, 16'h0010};
	logic [15:0] e [4] = '{16'h4000, 16'h4010, 16'h7fff, 16'h8000};
	mpp_top mpp_top_inst (.clock(clock), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datI), .wb_dat_o(datO),
		.wb_ack_o(ack), .convStart(convStart), .convSel(convSel),
		.tempExtSel(tempExtSel), .convDone(convDone), .convData(convData));
	mpp_conv_model mpp_conv_model_inst (.clock(clock), .rstn(rstn), .convStart(convStart),
		.convSel(convSel), .tempExtSel(tempExtSel), .convDone(convDone),
		.convData(convData));
	// ----------------------------------------
	// clock, path monitor, watchdog
	// ----------------------------------------
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	// path used by the last temperature conversion
	always @(posedge clock) if (convDone === 1'b1 && convSel === 3'b010) extSeen <= tempExtSel;
	initial begin
		#100000;
		miscompares++;
		results();
	end
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task check16(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// classic cycle, held until ack is sampled high
	task wbCycle(input logic w, input logic [7:0] idx, input logic [15:0] d,
		output logic [15:0] q);
		int n;
		@(posedge clock);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {idx, 2'b00};
		datI <= {16'h0000, d};
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (ack !== 1'b1) miscompares++;
		q = datO[15:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	task wr(input logic [7:0] idx, input logic [15:0] d);
		logic [15:0] q;
		wbCycle(1'b1, idx, d, q);
	endtask
	task rd(input logic [7:0] idx, input logic [15:0] exp);
		logic [15:0] q;
		wbCycle(1'b0, idx, 16'h0000, q);
		check16(q, exp);
	endtask
	// two voltage starts: a whole round ran on current trims
	task round;
		int n;
		n = 0;
		repeat (2) begin
			do begin
				@(posedge clock);
				n++;
			end while (!(convStart === 1'b1 && convSel === 3'b001) && n < 400);
		end
		if (n >= 400) miscompares++;
	endtask
	task results;
		$display("checked=%0d miscompares=%0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task testReset;
		rd(`MPP_IDX_THERMISTOR_GAIN_TRIM, 16'hee56);
		rd(`MPP_IDX_THERMISTOR_OFFSET_TRIM, 16'h1da4);
		rd(`MPP_IDX_CURRENT_GAIN_TRIM, 16'h0400);
		rd(`MPP_IDX_CURRENT_OFFSET_TRIM, 16'h0000);
		round();
		rd(`MPP_IDX_VOLT, 16'h1234);
		rd(`MPP_IDX_CURRENT, 16'h2000);
		rd(`MPP_IDX_TEMP, 16'h3200);
		check16({15'h0000, extSeen}, 16'h0000);
		$display("test reset and results done");
	endtask
	// gain, offset, then clipping at both ends
	task testTrim;
		for (int i = 0; i < 4; i++) begin
			wr(`MPP_IDX_CURRENT_GAIN_TRIM, g[i]);
			wr(`MPP_IDX_CURRENT_OFFSET_TRIM, o[i]);
			round();
			rd(`MPP_IDX_CURRENT, e[i]);
		end
		wr(`MPP_IDX_CURRENT_GAIN_TRIM, 16'h0400);
		wr(`MPP_IDX_CURRENT_OFFSET_TRIM, 16'h0000);
		$display("test current trim done");
	endtask
	// external path with curve byte, then back to die reading
	task testTemp;
		wr(`MPP_IDX_CURVE, 16'h0025);
		wr(`MPP_IDX_CTRL, 16'h0001);
		round();
		check16({15'h0000, extSeen}, 16'h0001);
		rd(`MPP_IDX_RATIO, 16'h0800);
		rd(`MPP_IDX_PCT, 16'h1900);
		rd(`MPP_IDX_TEMP, 16'h1bda);
		wr(`MPP_IDX_CTRL, 16'h0000);
		round();
		rd(`MPP_IDX_TEMP, 16'h3200);
		$display("test temperature paths done");
	endtask
	// unmapped and read-only places, then tempco and trace curve at a 50 degree die
	task testBus;
		rd(8'h50, 16'h0000);
		wr(`MPP_IDX_VOLT, 16'hffff);
		rd(`MPP_IDX_VOLT, 16'h1234);
		wr(`MPP_IDX_TEMPCO, 16'h20c8);
		rd(`MPP_IDX_TEMPCO, 16'h20c8);
		round();
		// 25 degrees over reference at about 0.4 percent per degree adds 818
		rd(`MPP_IDX_CURRENT, 16'h2332);
		wr(`MPP_IDX_TEMPCO, 16'h0000);
		wr(`MPP_IDX_CURVE, 16'h4000);
		round();
		rd(`MPP_IDX_CURRENT, 16'h2200);
		$display("test bus and tempco done");
	endtask
	initial begin
		rstn = 1'b0;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 10'h000;
		sel = 4'h3;
		datI = 32'h00000000;
		repeat (3) @(posedge clock);
		rstn <= 1'b1;
		testReset();
		testTrim();
		testTemp();
		testBus();
		results();
	end
endmodule // mpp_top_tb
